// ### rtl/fre_alu.sv
// Combinational datapath for the single-operand file and literal operations
`timescale 1ns/1ps
`default_nettype none
module fre_alu (
  fre_alu_if.alu  bus  // Operands in, result and controls out
);
  import fre_pkg::*;

  // ************************************************************
  // Result, destination and flag selection
  // ************************************************************
  always_comb begin
    bus.op       = fre_decode(bus.instr);
    bus.result   = bus.file_val;
    bus.to_file  = 1'b0;
    bus.to_w     = 1'b0;
    bus.upd_zero = 1'b0;
    bus.skip     = 1'b0;
    case (bus.op)
      FRE_OP_COMPLEMENT: begin
        bus.result   = ~bus.file_val;
        bus.upd_zero = 1'b1;
      end
      FRE_OP_DECREMENT: begin
        bus.result   = bus.file_val - 8'h01;
        bus.upd_zero = 1'b1;
      end
      FRE_OP_DEC_SKIP: begin
        bus.result   = bus.file_val - 8'h01;
        bus.skip     = fre_is_zero(bus.file_val - 8'h01);
      end
      FRE_OP_INCREMENT: begin
        bus.result   = bus.file_val + 8'h01;
        bus.upd_zero = 1'b1;
      end
      FRE_OP_INC_SKIP: begin
        bus.result   = bus.file_val + 8'h01;
        bus.skip     = fre_is_zero(bus.file_val + 8'h01);
      end
      FRE_OP_OR_LIT: begin
        bus.result   = bus.w_val | bus.instr[7:0];
        bus.upd_zero = 1'b1;
        bus.to_w     = 1'b1;
      end
      default: begin
        bus.result   = bus.file_val;
      end
    endcase
    // File operations pick their destination from the d bit
    if (bus.op inside {FRE_OP_COMPLEMENT, FRE_OP_DECREMENT, FRE_OP_DEC_SKIP,
                       FRE_OP_INCREMENT, FRE_OP_INC_SKIP}) begin
      bus.to_file = bus.instr[DEST_BIT];
      bus.to_w    = ~bus.instr[DEST_BIT];
    end
    bus.res_zero = fre_is_zero(bus.result);
  end

endmodule
`default_nettype wire

// ### rtl/fre_alu_if.sv
// Interface between the executor control and its datapath
`timescale 1ns/1ps
`default_nettype none
interface fre_alu_if;
  import fre_pkg::*;

  logic [INSTR_W-1:0] instr;     // Instruction being executed
  logic [DATA_W-1:0]  file_val;  // Value of the addressed file register
  logic [DATA_W-1:0]  w_val;     // Current working register
  fre_op_t            op;        // Decoded operation
  logic [DATA_W-1:0]  result;    // Eight-bit result
  logic               to_file;   // Result goes to the file register
  logic               to_w;      // Result goes to the working register
  logic               upd_zero;  // Zero flag is updated
  logic               res_zero;  // Result equals zero
  logic               skip;      // Prefetched word must be dropped

  modport ctrl (output instr, file_val, w_val,
                input  op, result, to_file, to_w, upd_zero, res_zero, skip);
  modport alu  (input  instr, file_val, w_val,
                output op, result, to_file, to_w, upd_zero, res_zero, skip);
endinterface
`default_nettype wire

// ### rtl/fre_exec.sv
// Top of the executor for single-operand file, OR-literal and branch instructions
`timescale 1ns/1ps
`default_nettype none
module fre_exec (
  input  wire logic                          clk_sys,        // Core clock, 100 MHz
  input  wire logic                          reset_n,        // Synchronous reset, active low
  input  wire logic                          instr_valid,    // Instruction word presented
  input  wire logic [fre_pkg::INSTR_W-1:0]   instr_word,     // Instruction word
  input  wire logic [fre_pkg::DATA_W-1:0]    file_rd_data,   // Addressed file register value
  input  wire logic [fre_pkg::DATA_W-1:0]    status_in,      // Current status register
  output logic [fre_pkg::DATA_W-1:0]         w_reg_ff,       // Working register
  output logic                               zero_ff,        // Zero flag
  output logic                               zero_we_ff,     // Zero flag updated, pulse
  output logic                               file_we_ff,     // File write strobe, pulse
  output logic [fre_pkg::FADDR_W-1:0]        file_waddr_ff,  // File write address
  output logic [fre_pkg::DATA_W-1:0]         file_wdata_ff,  // File write data
  output logic                               pc_load_ff,     // Program counter loaded, pulse
  output logic [fre_pkg::PC_W-1:0]           pc_target_ff,   // Program counter target
  output logic                               discard_ff      // Prefetched word dropped, pulse
);
  import fre_pkg::*;

  typedef enum {
    FRE_ST_RUN,
    FRE_ST_FLUSH
  } fre_state_t;

  fre_alu_if alu_bus ();

  fre_state_t            state_ff;
  fre_state_t            nxt_state;
  logic [DATA_W-1:0]     nxt_w_reg;
  logic                  nxt_zero;
  logic                  nxt_zero_we;
  logic                  nxt_file_we;
  logic [FADDR_W-1:0]    nxt_file_waddr;
  logic [DATA_W-1:0]     nxt_file_wdata;
  logic                  nxt_pc_load;
  logic [PC_W-1:0]       nxt_pc_target;
  logic                  nxt_discard;
  logic                  exec_en;
  logic                  br_take;
  logic                  skip_take;

  // ************************************************************
  // Datapath
  // ************************************************************
  // Timing of one slot, as seen at the ports:
  //   cycle 0  word, file value and status are offered with instr_valid
  //   edge     the word is taken if the slot is a run slot
  //   cycle 1  results, strobes and the new program counter target stand
  //   cycle 2  after a taken skip or branch, discard_ff marks the dropped slot
  // The file value is read combinationally in cycle 0, so a slow file read
  // path sets the clock period of the whole core.
  assign alu_bus.instr    = instr_word;
  assign alu_bus.file_val = file_rd_data;
  assign alu_bus.w_val    = w_reg_ff;

  fre_alu u_alu (
    .bus (alu_bus.alu)
  );

  // ************************************************************
  // Slot control
  // ************************************************************
  // Slot qualifiers; only a run slot acts on its word
  always_comb begin
    exec_en   = instr_valid && (state_ff == FRE_ST_RUN);
    br_take   = exec_en && (alu_bus.op == FRE_OP_BRANCH);
    skip_take = exec_en && alu_bus.skip;
  end

  // The slot after a taken skip or branch is spent as a no-operation,
  // so the prefetched word never executes
  always_comb begin
    nxt_state = FRE_ST_RUN;
    case (state_ff)
      FRE_ST_RUN: begin
        // A nonzero skip result leaves the next slot alone
        if (br_take || skip_take) begin
          nxt_state = FRE_ST_FLUSH;
        end
      end
      FRE_ST_FLUSH: begin
        // Exactly one slot is dropped, whether a word is offered or not
        nxt_state = FRE_ST_RUN;
      end
      default: begin
        nxt_state = FRE_ST_RUN;
      end
    endcase
  end

  // Slot state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff <= FRE_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // Working register and zero flag
  // ************************************************************
  // Skip forms never raise upd_zero, so they leave the flag alone
  always_comb begin
    nxt_w_reg   = w_reg_ff;
    nxt_zero    = zero_ff;
    nxt_zero_we = 1'b0;
    if (exec_en && alu_bus.to_w) begin
      nxt_w_reg = alu_bus.result;
    end
    if (exec_en && alu_bus.upd_zero) begin
      nxt_zero    = alu_bus.res_zero;
      nxt_zero_we = 1'b1;
    end
  end

  // Working register, flag and its update pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      w_reg_ff   <= RST_WORKING;
      zero_ff    <= RST_ZERO;
      zero_we_ff <= 1'b0;
    end else begin
      w_reg_ff   <= nxt_w_reg;
      zero_ff    <= nxt_zero;
      zero_we_ff <= nxt_zero_we;
    end
  end

  // ************************************************************
  // File write port
  // ************************************************************
  // Address and data hold between writes; only the strobe pulses, so the
  // file side must qualify every write with file_we_ff.
  // The file takes the write one edge later, so a word in the next slot that
  // reads the same register needs forwarding outside this block.
  always_comb begin
    nxt_file_we    = 1'b0;
    nxt_file_waddr = file_waddr_ff;
    nxt_file_wdata = file_wdata_ff;
    if (exec_en && alu_bus.to_file) begin
      nxt_file_we    = 1'b1;
      nxt_file_waddr = instr_word[FADDR_W-1:0];
      nxt_file_wdata = alu_bus.result;
    end
  end

  // File write strobe, address and data
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      file_we_ff    <= 1'b0;
      file_waddr_ff <= '0;
      file_wdata_ff <= '0;
    end else begin
      file_we_ff    <= nxt_file_we;
      file_waddr_ff <= nxt_file_waddr;
      file_wdata_ff <= nxt_file_wdata;
    end
  end

  // ************************************************************
  // Program counter load
  // ************************************************************
  // Page bits come from status_in as it stands in the branch's own cycle
  always_comb begin
    nxt_pc_load   = 1'b0;
    nxt_pc_target = pc_target_ff;
    if (br_take) begin
      nxt_pc_load   = 1'b1;
      nxt_pc_target = {status_in[PAGE_HI:PAGE_LO],
                       instr_word[BR_IMM_W-1:0]};
    end
  end

  // Program counter strobe and target
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pc_load_ff   <= 1'b0;
      pc_target_ff <= RST_PC;
    end else begin
      pc_load_ff   <= nxt_pc_load;
      pc_target_ff <= nxt_pc_target;
    end
  end

  // ************************************************************
  // Discard pulse
  // ************************************************************
  // Marks the dropped slot so the fetch side can tell the no-operation apart
  always_comb begin
    nxt_discard = 1'b0;
    if (state_ff == FRE_ST_FLUSH) begin
      nxt_discard = 1'b1;
    end
  end

  // Discard register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      discard_ff <= 1'b0;
    end else begin
      discard_ff <= nxt_discard;
    end
  end

endmodule
`default_nettype wire

// ### rtl/fre_pkg.sv
// Package with opcode patterns, field positions, reset values and shared types of the executor
`default_nettype none
package fre_pkg;

  // ************************************************************
  // Instruction word layout
  // ************************************************************
  localparam int unsigned INSTR_W    = 12;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 5;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned BR_IMM_W   = 9;
  localparam int unsigned DEST_BIT   = 5;
  localparam int unsigned PAGE_HI    = 6;
  localparam int unsigned PAGE_LO    = 5;

  // ************************************************************
  // Opcode patterns (upper bits of the word)
  // ************************************************************
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT  = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP   = 6'h0B;
  localparam logic [5:0] OPC_INCREMENT  = 6'h0A;
  localparam logic [5:0] OPC_INC_SKIP   = 6'h0F;
  localparam logic [3:0] OPC_OR_LIT     = 4'hD;
  localparam logic [2:0] OPC_BRANCH     = 3'h5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DATA_W-1:0]  RST_WORKING = 8'h00;
  localparam logic [PC_W-1:0]    RST_PC      = 11'h000;
  localparam logic               RST_ZERO    = 1'b0;

  typedef enum {
    FRE_OP_NONE,
    FRE_OP_COMPLEMENT,
    FRE_OP_DECREMENT,
    FRE_OP_DEC_SKIP,
    FRE_OP_INCREMENT,
    FRE_OP_INC_SKIP,
    FRE_OP_OR_LIT,
    FRE_OP_BRANCH
  } fre_op_t;

  // Map an instruction word onto the operation it asks for
  function automatic fre_op_t fre_decode(input logic [INSTR_W-1:0] word);
    fre_op_t op;
    op = FRE_OP_NONE;
    if (word[11:6] == OPC_COMPLEMENT) begin
      op = FRE_OP_COMPLEMENT;
    end else if (word[11:6] == OPC_DECREMENT) begin
      op = FRE_OP_DECREMENT;
    end else if (word[11:6] == OPC_DEC_SKIP) begin
      op = FRE_OP_DEC_SKIP;
    end else if (word[11:6] == OPC_INCREMENT) begin
      op = FRE_OP_INCREMENT;
    end else if (word[11:6] == OPC_INC_SKIP) begin
      op = FRE_OP_INC_SKIP;
    end else if (word[11:8] == OPC_OR_LIT) begin
      op = FRE_OP_OR_LIT;
    end else if (word[11:9] == OPC_BRANCH) begin
      op = FRE_OP_BRANCH;
    end
    return op;
  endfunction

  // Zero test shared by flag update and skip decision
  function automatic logic fre_is_zero(input logic [DATA_W-1:0] value);
    return (value == 8'h00);
  endfunction

endpackage
`default_nettype wire

// ### tb/fre_exec_properties.sv
// Checker of the executor's port behaviour
`timescale 1ns/1ps
`default_nettype none
module fre_exec_properties
  import fre_pkg::*;
(
  input wire logic               clk_sys,       // Clock
  input wire logic               reset_n,       // Reset
  input wire logic               instr_valid,   // Valid
  input wire logic [INSTR_W-1:0] instr_word,    // Word
  input wire logic [DATA_W-1:0]  file_rd_data,  // File
  input wire logic [DATA_W-1:0]  status_in,     // Status
  input wire logic [DATA_W-1:0]  w_reg_ff,      // W
  input wire logic               zero_ff,       // Zero
  input wire logic               zero_we_ff,    // Zero upd
  input wire logic               file_we_ff,    // Write
  input wire logic [FADDR_W-1:0] file_waddr_ff, // Addr
  input wire logic [DATA_W-1:0]  file_wdata_ff, // Data
  input wire logic               pc_load_ff,    // Load
  input wire logic [PC_W-1:0]    pc_target_ff,  // Target
  input wire logic               discard_ff     // Drop
);
  logic [11:0] wd_ff;                  // Previous word
  logic [7:0]  fl_ff, st_ff, res, fx;  // Old file, status; result; expected
  logic        skp, fop;               // Skip op, file op
  // History, since results show one edge after the word
  always_ff @(posedge clk_sys) begin
    wd_ff <= instr_word;
    fl_ff <= file_rd_data;
    st_ff <= status_in;
  end
  // Own decode, so a slip in the design's decode cannot hide
  assign skp = instr_word[11:6] inside {OPC_DEC_SKIP, OPC_INC_SKIP};
  assign fop = skp || (instr_word[11:6] inside {OPC_COMPLEMENT, OPC_DECREMENT, OPC_INCREMENT});
  assign res = wd_ff[5] ? file_wdata_ff : w_reg_ff;
  assign fx  = (wd_ff[11:6] == OPC_COMPLEMENT) ? ~fl_ff :
               (wd_ff[11:6] inside {OPC_INCREMENT, OPC_INC_SKIP}) ? fl_ff + 8'h01 :
               fl_ff - 8'h01;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ************
  // Checks: a word is taken when no discard pulse follows it
  // ************
  sequence f_tk; instr_valid && fop ##1 !discard_ff; endsequence
  sequence s_tk; instr_valid && skp ##1 !discard_ff; endsequence
  sequence o_tk; instr_valid && instr_word[11:8] == OPC_OR_LIT ##1 !discard_ff; endsequence
  sequence b_tk; instr_valid && instr_word[11:9] == OPC_BRANCH ##1 !discard_ff; endsequence
  calc_ok_a: assert property (f_tk |-> res == fx)
    else $error("file op result wrong");
  dest_ok_a: assert property (f_tk |-> file_we_ff == wd_ff[5] &&
    (!wd_ff[5] || (file_waddr_ff == wd_ff[4:0] && $stable(w_reg_ff))))
    else $error("destination wrong");
  zero_ok_a: assert property (zero_we_ff |->
    zero_ff == ((file_we_ff ? file_wdata_ff : w_reg_ff) == 8'h00))
    else $error("zero flag wrong");
  skip_flag_a: assert property (s_tk |-> !zero_we_ff && $stable(zero_ff))
    else $error("skip touched zero flag");
  skip_drop_a: assert property (s_tk |=> discard_ff == ($past(res) == 8'h00))
    else $error("skip drop wrong");
  or_lit_a: assert property (o_tk |-> zero_we_ff &&
    w_reg_ff == ($past(w_reg_ff) | wd_ff[7:0]))
    else $error("or literal wrong");
  br_tgt_a: assert property (b_tk |-> pc_load_ff &&
    pc_target_ff == {st_ff[6:5], wd_ff[8:0]})
    else $error("branch target wrong");
  br_drop_a: assert property (pc_load_ff |=>
    discard_ff && !file_we_ff && !zero_we_ff)
    else $error("branch slot not dropped");
  // Main scenarios reached
  cover property (b_tk ##1 discard_ff);
  cover property (s_tk ##1 discard_ff);
  cover property (o_tk ##0 zero_ff);
endmodule
bind fre_exec fre_exec_properties u_props (.clk_sys, .reset_n, .instr_valid, .instr_word,
  .file_rd_data, .status_in, .w_reg_ff, .zero_ff, .zero_we_ff, .file_we_ff, .file_waddr_ff,
  .file_wdata_ff, .pc_load_ff, .pc_target_ff, .discard_ff);
`default_nettype wire

// ### tb/fre_exec_tb.sv
// Self-checking bench of the executor: reference model, note queue, random words
`timescale 1ns/1ps
`default_nettype none
module fre_exec_tb;
  import fre_pkg::*;
  typedef struct packed {
    logic [7:0]  w;
    logic        z, zwe, fwe;
    logic [4:0]  ad;
    logic [7:0]  da;
    logic        pcl;
    logic [10:0] pct;
    logic        dis;
  } fre_obs_t;
  logic        clk_sys = 1'b0;  // Clock
  logic        reset_n = 1'b0;  // Reset
  logic        vld     = 1'b0;  // Word valid
  logic [11:0] word    = 12'h000;
  logic [7:0]  fdat    = 8'h00;
  logic [7:0]  stat    = 8'h00;
  logic [11:0] rw;                 // Random word
  logic [31:0] rs = 32'h818DBD45;  // Random state
  logic        drop = 1'b0;        // Slot is dropped
  logic        pend = 1'b0;        // Note not yet queued
  fre_obs_t    o, m, e, q[$];      // Seen, model, expected, notes
  int          err_total = 0;
  int          cmp_count = 0;
  fre_exec dut (.clk_sys, .reset_n, .instr_valid(vld), .instr_word(word), .file_rd_data(fdat),
    .status_in(stat), .w_reg_ff(o.w), .zero_ff(o.z), .zero_we_ff(o.zwe), .file_we_ff(o.fwe),
    .file_waddr_ff(o.ad), .file_wdata_ff(o.da), .pc_load_ff(o.pcl), .pc_target_ff(o.pct),
    .discard_ff(o.dis));
  always #5 clk_sys = ~clk_sys;
  // A hang ends the run; the tests need about 4.3 us
  initial begin
    #20000;
    err_total++;
    end_sim;
  end
  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] sv, input logic [15:0] ev);
    cmp_count++;
    if (sv !== ev) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, ev, sv);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Drive one slot; its note is queued a cycle later, when the result is due
  task automatic step(input logic v, input logic [11:0] wd,
                      input logic [7:0] f, input logic [7:0] s);
    logic [7:0] r;
    logic       nd;
    @(posedge clk_sys);
    #1;
    if (pend)
      q.push_back(m);
    pend = 1'b1;
    vld = v;
    word = wd;
    fdat = f;
    stat = s;
    nd = 1'b0;
    {m.zwe, m.fwe, m.pcl} = 3'b000;
    m.dis = drop;
    if (!drop && v) begin
      if (wd[11:6] inside {OPC_COMPLEMENT, OPC_DECREMENT, OPC_DEC_SKIP,
                           OPC_INCREMENT, OPC_INC_SKIP}) begin
        r = (wd[11:6] == OPC_COMPLEMENT) ? ~f :
            (wd[11:6] inside {OPC_DECREMENT, OPC_DEC_SKIP}) ? f - 8'h01 : f + 8'h01;
        if (wd[5])
          {m.fwe, m.ad, m.da} = {1'b1, wd[4:0], r};
        else
          m.w = r;
        if (wd[11:6] inside {OPC_DEC_SKIP, OPC_INC_SKIP})
          nd = (r == 8'h00);
        else
          {m.z, m.zwe} = {r == 8'h00, 1'b1};
      end else if (wd[11:8] == OPC_OR_LIT) begin
        m.w = m.w | wd[7:0];
        {m.z, m.zwe} = {m.w == 8'h00, 1'b1};
      end else if (wd[11:9] == OPC_BRANCH) begin
        {m.pcl, m.pct, nd} = {1'b1, s[6:5], wd[8:0], 1'b1};
      end
    end
    drop = nd;
  endtask
  // Compare the oldest note with the outputs after each edge
  initial begin
    forever begin
      @(posedge clk_sys);
      #2;
      if (q.size() > 0) begin
        e = q.pop_front();
        chk("w_reg", 16'(o.w), 16'(e.w));
        chk("zero", 16'({o.z, o.zwe}), 16'({e.z, e.zwe}));
        chk("file_wr", 16'({o.fwe, o.ad, o.da}), 16'({e.fwe, e.ad, e.da}));
        chk("pc", 16'({o.pcl, o.pct}), 16'({e.pcl, e.pct}));
        chk("discard", 16'(o.dis), 16'(e.dis));
      end
    end
  end
  // Corner words back to back, then random traffic
  initial begin
    m = '0;
    repeat (16) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    step(1'b1, {OPC_COMPLEMENT, 6'h03}, 8'hFF, 8'h00);
    step(1'b1, {OPC_OR_LIT, 8'h00}, 8'h5A, 8'h00);
    step(1'b1, {OPC_INC_SKIP, 6'h27}, 8'hFF, 8'h00);
    step(1'b1, {OPC_INCREMENT, 6'h00}, 8'h10, 8'h00);
    step(1'b1, {OPC_BRANCH, 9'h1FF}, 8'h00, 8'h60);
    step(1'b1, {OPC_BRANCH, 9'h001}, 8'h00, 8'h20);
    step(1'b1, {OPC_DEC_SKIP, 6'h01}, 8'h01, 8'h00);
    step(1'b0, 12'h000, 8'h00, 8'h00);
    step(1'b1, {OPC_DEC_SKIP, 6'h22}, 8'h05, 8'h00);
    step(1'b1, {OPC_DECREMENT, 6'h21}, 8'h00, 8'h00);
    step(1'b1, 12'h000, 8'h33, 8'h00);
    repeat (400) begin
      rs = lfsr(rs);
      rw = rs[11:0];
      case (rs[14:12])
        3'h0: rw[11:6] = OPC_COMPLEMENT;
        3'h1: rw[11:6] = OPC_DECREMENT;
        3'h2: rw[11:6] = OPC_DEC_SKIP;
        3'h3: rw[11:6] = OPC_INCREMENT;
        3'h4: rw[11:6] = OPC_INC_SKIP;
        3'h5: rw[11:8] = OPC_OR_LIT;
        3'h6: rw[11:9] = OPC_BRANCH;
        default: ;
      endcase
      step(rs[15] | rs[16], rw, rs[23] ? (rs[22] ? 8'hFF : 8'h01) : rs[31:24], rs[30:23]);
    end
    step(1'b0, 12'h000, 8'h00, 8'h00);
    step(1'b0, 12'h000, 8'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    end_sim;
  end
endmodule
`default_nettype wire
